// file: verilog/session_consts.svh
// Named constants for the remote session responder: codes, offsets, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SESSION_CONSTS_SVH
`define SESSION_CONSTS_SVH

// Response codes
`define RSP_NEGATIVE 8'h00
`define RSP_COMPLETION 8'h01
`define RSP_PROGRESS 8'h02

// Command codes
`define CMD_OPEN_LINK 8'h10
`define CMD_CLOSE_LINK 8'h11

// Reason codes
`define REASON_NONE 8'h00
`define REASON_UNOPENED 8'h01
`define REASON_ACCESS_DENIED 8'h02
`define REASON_UNKNOWN_OP 8'h03
`define REASON_BAD_ITEM 8'h04
`define REASON_BAD_INDEX 8'h05
`define REASON_TYPE_MISMATCH 8'h06
`define REASON_BAD_LENGTH 8'h07
`define REASON_OUT_OF_RANGE 8'h08
`define REASON_WRITE_PROTECTED 8'h09
`define REASON_UNIMPLEMENTED 8'h0A
`define REASON_OUT_OF_ORDER 8'h0B
`define REASON_NO_SPACE 8'h0C
`define REASON_NVM_FAILURE 8'h0D

// Open-link payload
`define OPEN_FIXED_BYTES 3
`define OPEN_VERSION 8'h00
`define RATE_MAX 8'h02
`define RATE_9600 2'h0
`define RATE_19200 2'h1
`define SECRET_LENGTH_DEF 8
`define NEG_LEN 16'h0001

// Baud rates and clock
`define CLK_HZ 50000000
`define BAUD_0 9600
`define BAUD_1 19200
`define BAUD_2 28800

// Progress replies during a test: one per 100 ms at most
`define PROGRESS_GAP_MS 100
`define MS_PER_S 1000

// Register byte offsets
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_SECRET_BASE 8'h10
`define CTRL_SECRET_SET_BIT 0

`endif

// file: verilog/session_pkg.sv
// Types shared by the remote session responder.
// Assumes session_consts.svh is on the include path.
`include "session_consts.svh"
package session_pkg;
    typedef enum logic [2:0] {
        SESS_NONE = 3'b001,
        SESS_RESTRICTED = 3'b010,
        SESS_FULL = 3'b100
    } session_e;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_EXEC = 2'b10
    } phase_e;
endpackage : session_pkg

// file: verilog/remote_session_responder.sv
// Response and session layer of the line-based remote command protocol.
// Assumes a framer ahead that checks hex, length, CRC and line start, and a
// serializer behind that builds the reply frame and reports when it is sent.
// Summary of operation
// R1: Floats are four bytes, eight upper-case hex digits, most significant byte first.
// R2: Calendar record: big-endian 16-bit year, then month, day, hour, minute, second bytes.
// R3: Well-wrapped but malformed, unknown or unexecutable commands get a negative reply.
// R4: A negative reply carries exactly one data byte, the reason code.
// R5: Reasons 1 unopened, 2 access denied, 3 unknown command.
// R6: Reasons 4 bad item, 5 index too large, 6 type mismatch.
// R7: Reasons 7 bad length, 8 out of range, 9 write protected.
// R8: Reasons 10 unimplemented, 11 out of order, 12 no space, 13 memory failure.
// R9: A fully processed command gets a completion reply, with or without data.
// R10: A running command gets progress replies, then a completion or negative reply.
// R11: Flash work gets one empty progress reply; host waits up to 30 seconds.
// R12: Test progress replies carry readings, at most ten per second.
// R13: Open-link comes first; a repeated open-link is accepted any time.
// R14: Open payload: version, rate, seed, secret; wrong item, index or size is refused.
// R15: A protocol version other than zero is refused as out of range.
// R16: Rate code 0, 1, 2 picks 9600, 19200, 28800 baud; others refused.
// R17: The open reply goes at the old rate; the new rate follows after it.
// R18: Listen at 9600 baud after reset and after close-link.
// R19: The host tries open-link at 9600 baud first, then higher rates.
// R20: With no secret set, the session is unrestricted; seed and secret ignored.
// R21: Secret set and seed zero: restricted session, secret bytes ignored.
// R22: Secret set and seed nonzero: unscramble and compare; mismatch is refused.
// R23: Reply holds echoed sequence, code, length, data; serializer adds CRC and return.
// R24: Frames the framer flags as bad are dropped silently.
// R25: Close-link drops any unlocked state and returns to 9600 baud.
// R26: Secret length and unscramble function are parameters; compare to stored secret.
// R27: Session state is none, restricted or unrestricted; none after reset and close.
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "session_consts.svh"

module remote_session_responder import session_pkg::*; #(
    parameter int SECRET_LENGTH = `SECRET_LENGTH_DEF,
    parameter int PROGRESS_GAP_CYC = `CLK_HZ / `MS_PER_S * `PROGRESS_GAP_MS
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    // Decoded request from the framer
    input wire logic I_FRAME_VALID,
    input wire logic I_FRAME_OK,
    input wire logic [7:0] I_SEQ,
    input wire logic [7:0] I_CMD,
    input wire logic [7:0] I_ITEM,
    input wire logic [7:0] I_INST,
    input wire logic [15:0] I_DATASZ,
    input wire logic [8*(`OPEN_FIXED_BYTES+SECRET_LENGTH)-1:0] I_PAYLOAD,
    input wire logic I_CMD_PRIV,
    // Command executor
    output logic O_EXEC_REQ,
    output logic O_EXEC_READY,
    input wire logic I_EXEC_FINAL,
    input wire logic I_EXEC_NAK,
    input wire logic I_EXEC_INTERIM,
    input wire logic I_EXEC_FLASH,
    input wire logic [7:0] I_EXEC_REASON,
    input wire logic [15:0] I_EXEC_LEN,
    input wire logic [31:0] I_EXEC_DATA,
    // Reply to the serializer
    output logic O_RSP_VALID,
    input wire logic I_RSP_READY,
    output logic [7:0] O_RSP_SEQ,
    output logic [7:0] O_RSP_CODE,
    output logic [15:0] O_RSP_LEN,
    output logic [31:0] O_RSP_DATA,
    input wire logic I_TX_DONE,
    // Line rate
    output logic [1:0] O_BAUD_SEL,
    output logic O_BIT_TICK,
    // Register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA
);
    localparam int PAY_BYTES = `OPEN_FIXED_BYTES + SECRET_LENGTH;
    localparam int PW_WORDS = (SECRET_LENGTH + 3) / 4;
    localparam int GW = $clog2(PROGRESS_GAP_CYC + 1);

    // Seed-based unscramble of one secret byte
    function automatic logic [7:0] unscramble(input logic [7:0] b, input logic [7:0] seed, input logic [7:0] idx);
        unscramble = b ^ (seed + idx); // [R26]
    endfunction : unscramble

    // Cycles per bit at a given rate code
    function automatic logic [15:0] bit_cycles(input logic [1:0] code);
        case (code)
            `RATE_9600: bit_cycles = 16'(`CLK_HZ / `BAUD_0);
            `RATE_19200: bit_cycles = 16'(`CLK_HZ / `BAUD_1);
            default: bit_cycles = 16'(`CLK_HZ / `BAUD_2);
        endcase
    endfunction : bit_cycles

    session_e session;
    phase_e phase;
    logic rsp_pending;
    logic [7:0] cur_seq;
    logic [7:0] rsp_code;
    logic [15:0] rsp_len;
    logic [31:0] rsp_data;
    logic exec_req;
    logic flash_sent;
    logic [GW-1:0] gap_cnt;
    logic [1:0] baud_sel;
    logic baud_pending;
    logic [1:0] baud_next;
    logic [15:0] div_cnt;
    logic bit_tick;
    logic secret_set;
    logic [7:0] secret [SECRET_LENGTH];
    logic [31:0] rdata;

    // Request decode
    logic frame_take;
    logic is_open;
    logic is_close;
    logic [7:0] open_version;
    logic [7:0] open_rate;
    logic [7:0] open_seed;
    logic pw_match;
    logic [7:0] open_reason;
    logic [7:0] close_reason;
    logic [7:0] other_reason;
    logic [7:0] frame_reason;
    logic local_reply;
    logic go_exec;
    session_e open_session;

    assign frame_take = I_FRAME_VALID && I_FRAME_OK && phase == PH_IDLE && !rsp_pending; // [R24]
    assign is_open = I_CMD == `CMD_OPEN_LINK;
    assign is_close = I_CMD == `CMD_CLOSE_LINK;
    assign open_version = I_PAYLOAD[8*PAY_BYTES-1 -: 8]; // [R14]
    assign open_rate = I_PAYLOAD[8*PAY_BYTES-9 -: 8];
    assign open_seed = I_PAYLOAD[8*PAY_BYTES-17 -: 8];

    always_comb begin
        pw_match = 1'b1;
        for (int i = 0; i < SECRET_LENGTH; i++) begin
            if (unscramble(I_PAYLOAD[8*(SECRET_LENGTH-1-i) +: 8], open_seed, 8'(i)) != secret[i]) begin
                pw_match = 1'b0; // [R22] [R26]
            end
        end
    end

    assign open_reason = (I_ITEM != 8'h00) ? `REASON_BAD_ITEM : // [R14]
        (I_INST != 8'h00) ? `REASON_BAD_INDEX :
        (I_DATASZ != 16'(PAY_BYTES)) ? `REASON_BAD_LENGTH :
        (open_version != `OPEN_VERSION) ? `REASON_OUT_OF_RANGE : // [R15]
        (open_rate > `RATE_MAX) ? `REASON_OUT_OF_RANGE : // [R16]
        (secret_set && open_seed != 8'h00 && !pw_match) ? `REASON_ACCESS_DENIED : // [R22]
        `REASON_NONE;
    assign close_reason = (I_ITEM != 8'h00) ? `REASON_BAD_ITEM :
        (I_INST != 8'h00) ? `REASON_BAD_INDEX :
        (I_DATASZ != 16'h0000) ? `REASON_BAD_LENGTH : `REASON_NONE;
    assign other_reason = (session == SESS_NONE) ? `REASON_UNOPENED : // [R13] [R5]
        (session == SESS_RESTRICTED && I_CMD_PRIV) ? `REASON_ACCESS_DENIED : `REASON_NONE; // [R21]
    assign frame_reason = is_open ? open_reason : is_close ? close_reason : other_reason;
    assign local_reply = is_open || is_close || frame_reason != `REASON_NONE;
    assign go_exec = frame_take && !local_reply;
    // Unrestricted unless a secret is set and no secret was offered
    assign open_session = (secret_set && open_seed == 8'h00) ? SESS_RESTRICTED : SESS_FULL; // [R20] [R21]

    // Executor answers
    logic exec_ready;
    logic exec_end;
    logic exec_mid;
    logic progress_take;
    logic flash_take;
    logic rsp_load;
    logic [7:0] exec_reason;
    logic [7:0] next_rsp_code;
    logic [15:0] next_rsp_len;
    logic [31:0] next_rsp_data;

    assign exec_ready = phase == PH_EXEC && !rsp_pending;
    assign exec_end = exec_ready && (I_EXEC_FINAL || I_EXEC_NAK); // [R10]
    assign progress_take = I_EXEC_INTERIM && gap_cnt == '0; // [R12]
    assign flash_take = I_EXEC_FLASH && !flash_sent; // [R11]
    assign exec_mid = exec_ready && !exec_end && (progress_take || flash_take);
    assign rsp_load = (frame_take && local_reply) || exec_end || exec_mid;
    assign exec_reason = (I_EXEC_REASON == `REASON_NONE) ? `REASON_UNIMPLEMENTED : I_EXEC_REASON; // [R3] [R6] [R7] [R8]

    assign next_rsp_code = frame_take ? ((frame_reason != `REASON_NONE) ? `RSP_NEGATIVE : `RSP_COMPLETION) :
        exec_end ? (I_EXEC_NAK ? `RSP_NEGATIVE : `RSP_COMPLETION) : `RSP_PROGRESS; // [R9] [R10] [R3]
    assign next_rsp_len = frame_take ? ((frame_reason != `REASON_NONE) ? `NEG_LEN : 16'h0000) :
        (exec_end && I_EXEC_NAK) ? `NEG_LEN : // [R4]
        (exec_mid && !progress_take) ? 16'h0000 : I_EXEC_LEN; // [R11]
    assign next_rsp_data = frame_take ? {24'h000000, frame_reason} :
        (exec_end && I_EXEC_NAK) ? {24'h000000, exec_reason} : // [R4]
        (exec_mid && !progress_take) ? 32'h00000000 : I_EXEC_DATA; // [R1] [R2]

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            session <= SESS_NONE; // [R27]
            phase <= PH_IDLE;
            exec_req <= 1'b0;
            flash_sent <= 1'b0;
        end else begin
            exec_req <= go_exec;
            if (frame_take && is_open && open_reason == `REASON_NONE) begin
                session <= open_session; // [R13] [R20] [R21] [R22]
            end else if (frame_take && is_close && close_reason == `REASON_NONE) begin
                session <= SESS_NONE; // [R25] [R27]
            end
            if (go_exec) begin
                phase <= PH_EXEC;
                flash_sent <= 1'b0;
            end else if (exec_end) begin
                phase <= PH_IDLE;
            end else if (exec_mid && flash_take && !progress_take) begin
                flash_sent <= 1'b1; // [R11]
            end
        end
    end

    // Reply holding register, released by the serializer
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            rsp_pending <= 1'b0;
            cur_seq <= 8'h00;
            rsp_code <= `RSP_NEGATIVE;
            rsp_len <= 16'h0000;
            rsp_data <= 32'h00000000;
        end else begin
            if (frame_take) begin
                cur_seq <= I_SEQ; // [R23]
            end
            if (rsp_load) begin
                rsp_pending <= 1'b1;
                rsp_code <= next_rsp_code; // [R23]
                rsp_len <= next_rsp_len;
                rsp_data <= next_rsp_data;
            end else if (I_RSP_READY) begin
                rsp_pending <= 1'b0;
            end
        end
    end

    // Progress spacing timer
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            gap_cnt <= '0;
        end else if (exec_mid && progress_take) begin
            gap_cnt <= GW'(PROGRESS_GAP_CYC - 1); // [R12]
        end else if (gap_cnt != '0) begin
            gap_cnt <= gap_cnt - 1'b1;
        end
    end

    // Line rate: changes only once the reply at the old rate is out
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            baud_sel <= `RATE_9600; // [R18]
            baud_pending <= 1'b0;
            baud_next <= `RATE_9600;
        end else begin
            if (frame_take && is_open && open_reason == `REASON_NONE) begin
                baud_pending <= 1'b1;
                baud_next <= open_rate[1:0]; // [R16]
            end else if (frame_take && is_close && close_reason == `REASON_NONE) begin
                baud_pending <= 1'b1;
                baud_next <= `RATE_9600; // [R18] [R25]
            end else if (I_TX_DONE && baud_pending && !rsp_pending) begin
                baud_pending <= 1'b0;
                baud_sel <= baud_next; // [R17]
            end
        end
    end

    // Bit-rate enable pulse
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N || div_cnt >= bit_cycles(baud_sel) - 16'h0001) begin
            div_cnt <= 16'h0000;
            bit_tick <= I_RESET_N;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            bit_tick <= 1'b0;
        end
    end

    // Register port
    logic wr_control;
    logic wr_secret;
    logic [7:0] secret_word;
    logic [31:0] status_word;

    assign wr_control = I_WR && I_ADDR == `REG_CONTROL;
    assign secret_word = (I_ADDR - `REG_SECRET_BASE) >> 2;
    assign wr_secret = I_WR && I_ADDR >= `REG_SECRET_BASE && I_ADDR[1:0] == 2'h0 && secret_word < 8'(PW_WORDS);
    assign status_word = {24'h000000, phase == PH_EXEC, rsp_pending, baud_pending, baud_sel, session};

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            secret_set <= 1'b0;
            for (int i = 0; i < SECRET_LENGTH; i++) begin
                secret[i] <= 8'h00;
            end
        end else begin
            if (wr_control) begin
                secret_set <= I_WDATA[`CTRL_SECRET_SET_BIT];
            end
            for (int i = 0; i < SECRET_LENGTH; i++) begin
                if (wr_secret && 8'(i / 4) == secret_word) begin
                    secret[i] <= I_WDATA[8*(3-i%4) +: 8]; // [R26]
                end
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N || !I_RD) begin
            rdata <= 32'h00000000;
        end else if (I_ADDR == `REG_CONTROL) begin
            rdata <= {31'h00000000, secret_set};
        end else if (I_ADDR == `REG_STATUS) begin
            rdata <= status_word;
        end else begin
            rdata <= 32'h00000000;
        end
    end

    assign O_EXEC_REQ = exec_req;
    assign O_EXEC_READY = exec_ready;
    assign O_RSP_VALID = rsp_pending;
    assign O_RSP_SEQ = cur_seq;
    assign O_RSP_CODE = rsp_code;
    assign O_RSP_LEN = rsp_len;
    assign O_RSP_DATA = rsp_data;
    assign O_BAUD_SEL = baud_sel;
    assign O_BIT_TICK = bit_tick;
    assign O_RDATA = rdata;

    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);

    chk_neg_one_byte: assert property (O_RSP_VALID && O_RSP_CODE == `RSP_NEGATIVE |-> O_RSP_LEN == `NEG_LEN) // [R4]
        else $error("negative reply length not one");
    chk_neg_reason_range: assert property (O_RSP_VALID && O_RSP_CODE == `RSP_NEGATIVE |->
        O_RSP_DATA[7:0] >= `REASON_UNOPENED && O_RSP_DATA[7:0] <= `REASON_NVM_FAILURE) // [R5]
        else $error("negative reason out of range");
    chk_unopened_refused: assert property (frame_take && !is_open && !is_close && session == SESS_NONE |=>
        O_RSP_VALID && O_RSP_CODE == `RSP_NEGATIVE && O_RSP_DATA[7:0] == `REASON_UNOPENED && !O_EXEC_REQ) // [R13]
        else $error("command before open not refused");
    chk_version_check: assert property (frame_take && is_open && I_ITEM == 8'h00 && I_INST == 8'h00 &&
        I_DATASZ == 16'(PAY_BYTES) && open_version != `OPEN_VERSION |=>
        O_RSP_CODE == `RSP_NEGATIVE && O_RSP_DATA[7:0] == `REASON_OUT_OF_RANGE) // [R15]
        else $error("bad version not refused");
    chk_rate_check: assert property (frame_take && is_open && open_reason == `REASON_NONE |=>
        O_RSP_CODE == `RSP_COMPLETION && baud_next == $past(open_rate[1:0])) // [R16]
        else $error("valid open not completed");
    chk_rate_after_tx: assert property (O_BAUD_SEL != $past(O_BAUD_SEL) |-> $past(I_TX_DONE) && !$past(rsp_pending)) // [R17]
        else $error("rate changed before reply sent");
    chk_close_clears: assert property (frame_take && is_close && close_reason == `REASON_NONE |=>
        session == SESS_NONE && baud_next == `RATE_9600) // [R25]
        else $error("close did not clear session");
    chk_secret_refused: assert property (frame_take && is_open && secret_set && open_seed != 8'h00 && !pw_match &&
        I_ITEM == 8'h00 && I_INST == 8'h00 && I_DATASZ == 16'(PAY_BYTES) && open_version == `OPEN_VERSION &&
        open_rate <= `RATE_MAX |=> O_RSP_DATA[7:0] == `REASON_ACCESS_DENIED && $stable(session)) // [R22]
        else $error("wrong secret accepted");
    chk_progress_gap: assert property (exec_mid && progress_take |=> gap_cnt == GW'(PROGRESS_GAP_CYC - 1)) // [R12]
        else $error("progress spacing not started");
    chk_seq_echo: assert property (frame_take |=> O_RSP_SEQ == $past(I_SEQ)) // [R23]
        else $error("sequence not echoed");

    cov_open_full: cover property (frame_take && is_open && open_reason == `REASON_NONE && open_session == SESS_FULL);
    cov_exec_final: cover property (go_exec ##[1:20] exec_end && I_EXEC_FINAL);
    cov_rate_switch: cover property (baud_pending ##1 O_BAUD_SEL != `RATE_9600);
endmodule : remote_session_responder
`default_nettype wire

// file: verification/reply_sink.sv
// Serializer stand-in: takes each reply and reports it sent some cycles later.
// Assumes the responder holds its reply valid until ready is seen high.
`timescale 1ns/1ps
`default_nettype none
module reply_sink (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Reply handshake
    input wire logic i_valid,
    input wire logic i_slow,
    output logic o_ready,
    output logic o_tx_done
);
    logic busy;
    logic [3:0] cnt;
    always_ff @(posedge i_clk) begin
        o_tx_done <= 1'b0;
        if (!i_rst_n) begin
            o_ready <= 1'b0;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (o_ready) begin
            o_ready <= 1'b0;
            busy <= 1'b1;
            cnt <= i_slow ? 4'hC : 4'h2;
        end else if (busy) begin
            cnt <= cnt - 4'h1;
            busy <= cnt != 4'h0;
            // Last character gone: the responder may now switch rate
            o_tx_done <= cnt == 4'h0;
        end else if (i_valid) begin
            o_ready <= 1'b1;
        end
    end
endmodule : reply_sink
`default_nettype wire

// file: verification/test_remote_session_responder.sv
// Self-checking bench for the remote session responder.
// Assumes session_consts.svh on the include path and reply_sink as far side.
`timescale 1ns/1ps
`default_nettype none
`include "session_consts.svh"
module test_remote_session_responder import session_pkg::*;;
    localparam int PW = 8 * (`OPEN_FIXED_BYTES + `SECRET_LENGTH_DEF);
    localparam logic [15:0] OSZ = 16'(`OPEN_FIXED_BYTES + `SECRET_LENGTH_DEF);
    localparam int TICK1 = `CLK_HZ / `BAUD_1;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fv = 1'b0;
    logic fok = 1'b0;
    logic priv = 1'b0;
    logic slow = 1'b0;
    logic [7:0] seq = 8'h00;
    logic [7:0] cmd = 8'h00;
    logic [7:0] item = 8'h00;
    logic [7:0] inst = 8'h00;
    logic [15:0] sz = 16'h0000;
    logic [PW-1:0] pl = '0;
    logic e_fin = 1'b0;
    logic e_nak = 1'b0;
    logic e_int = 1'b0, e_fl = 1'b0;
    logic [7:0] e_rsn = 8'h00;
    logic [15:0] e_len = 16'h0000;
    logic [31:0] e_dat = 32'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic exec_req, exec_ready, rsp_valid, rsp_ready, tx_done, tick;
    logic [7:0] rsp_seq, rsp_code;
    logic [15:0] rsp_len;
    logic [31:0] rsp_data, rdata;
    logic [1:0] baud;
    int errors = 0;
    int num_checks = 0;
    int waited = 0;
    wire [3:0] evs = {tick, exec_ready, tx_done, rsp_valid};

    always #10 clk = ~clk;

    remote_session_responder #(.PROGRESS_GAP_CYC(20)) DUT (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
        .I_FRAME_VALID(fv), .I_FRAME_OK(fok), .I_SEQ(seq), .I_CMD(cmd), .I_ITEM(item), .I_INST(inst),
        .I_DATASZ(sz), .I_PAYLOAD(pl), .I_CMD_PRIV(priv), .O_EXEC_REQ(exec_req), .O_EXEC_READY(exec_ready),
        .I_EXEC_FINAL(e_fin), .I_EXEC_NAK(e_nak), .I_EXEC_INTERIM(e_int), .I_EXEC_FLASH(e_fl),
        .I_EXEC_REASON(e_rsn), .I_EXEC_LEN(e_len), .I_EXEC_DATA(e_dat), .O_RSP_VALID(rsp_valid),
        .I_RSP_READY(rsp_ready), .O_RSP_SEQ(rsp_seq), .O_RSP_CODE(rsp_code), .O_RSP_LEN(rsp_len),
        .O_RSP_DATA(rsp_data), .I_TX_DONE(tx_done), .O_BAUD_SEL(baud), .O_BIT_TICK(tick),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));

    reply_sink u_sink (.i_clk(clk), .i_rst_n(rst_n), .i_valid(rsp_valid), .i_slow(slow),
        .o_ready(rsp_ready), .o_tx_done(tx_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ev(input int k);
        waited = 0;
        do begin
            @(posedge clk);
            #1;
            waited++;
        end while (evs[k] !== 1'b1 && waited < 6000);
        chk({31'h0, evs[k]}, 32'h1);
    endtask : wait_ev

    task automatic wrreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wrreg

    task automatic st(input logic [4:0] exp);
        @(posedge clk);
        addr <= `REG_STATUS;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk({27'h0, rdata[4:0]}, {27'h0, exp});
    endtask : st

    function automatic logic [PW-1:0] pay(input logic [7:0] ver, rate, seed, input logic flip);
        logic [PW-1:0] p;
        p = '0;
        p[PW-1 -: 24] = {ver, rate, seed};
        for (int i = 0; i < `SECRET_LENGTH_DEF; i++)
            p[PW-25-8*i -: 8] = (8'hA0 + 8'(i)) ^ (seed + 8'(i)) ^ {7'h00, flip};
        return p;
    endfunction : pay

    task automatic frame(input logic ok, input logic [7:0] c, it, ins, input logic [15:0] s,
                         input logic [PW-1:0] p, input logic pr);
        @(posedge clk);
        fv <= 1'b1;
        fok <= ok;
        cmd <= c;
        item <= it;
        inst <= ins;
        sz <= s;
        pl <= p;
        priv <= pr;
        seq <= seq + 8'h01;
        @(posedge clk);
        fv <= 1'b0;
    endtask : frame

    task automatic open(input logic [7:0] rate, seed, input logic flip);
        frame(1'b1, `CMD_OPEN_LINK, 8'h00, 8'h00, OSZ, pay(8'h00, rate, seed, flip), 1'b0);
    endtask : open

    task automatic reply(input logic [7:0] code, input logic [31:0] d, input logic [15:0] len,
                         input logic [1:0] b0, b1);
        wait_ev(0);
        chk({24'h0, rsp_code}, {24'h0, code});
        chk({16'h0, rsp_len}, {16'h0, len});
        chk({24'h0, rsp_seq}, {24'h0, seq});
        chk({30'h0, baud}, {30'h0, b0});
        if (len == 16'h0001)
            chk({24'h0, rsp_data[7:0]}, d);
        else if (len != 16'h0000)
            chk(rsp_data, d);
        wait_ev(1);
        @(posedge clk);
        #1;
        chk({30'h0, baud}, {30'h0, b1});
    endtask : reply

    task automatic exec(input logic f, n, i, fl, input logic [7:0] r, input logic [15:0] l, input logic [31:0] d);
        wait_ev(2);
        @(posedge clk);
        {e_fin, e_nak, e_int, e_fl} <= {f, n, i, fl};
        e_rsn <= r;
        e_len <= l;
        e_dat <= d;
        @(posedge clk);
        {e_fin, e_nak, e_int, e_fl} <= 4'h0;
    endtask : exec

    task automatic t_idle;
        st({2'b00, SESS_NONE});
        frame(1'b1, 8'h22, 8'h00, 8'h00, 16'h0, '0, 1'b0);
        reply(`RSP_NEGATIVE, `REASON_UNOPENED, `NEG_LEN, 2'h0, 2'h0);
        frame(1'b0, `CMD_OPEN_LINK, 8'h00, 8'h00, OSZ, pay(8'h00, 8'h01, 8'h00, 1'b0), 1'b0);
        repeat (10) @(posedge clk);
        #1;
        chk({31'h0, rsp_valid}, 32'h0);
    endtask : t_idle

    task automatic t_refuse;
        logic [7:0] rsn [5] = '{`REASON_BAD_ITEM, `REASON_BAD_INDEX, `REASON_BAD_LENGTH,
                                `REASON_OUT_OF_RANGE, `REASON_OUT_OF_RANGE};
        for (int k = 0; k < 5; k++) begin
            frame(1'b1, `CMD_OPEN_LINK, {7'h0, k == 0}, {7'h0, k == 1}, OSZ + {15'h0, k == 2},
                  pay({7'h0, k == 3}, (k == 4) ? 8'h03 : 8'h01, 8'h00, 1'b0), 1'b0);
            reply(`RSP_NEGATIVE, rsn[k], `NEG_LEN, 2'h0, 2'h0);
        end
        st({2'b00, SESS_NONE});
    endtask : t_refuse

    task automatic t_rate;
        open(8'h01, 8'h00, 1'b0);
        reply(`RSP_COMPLETION, 32'h0, 16'h0, 2'h0, 2'h1);
        st({2'b01, SESS_FULL});
        wait_ev(3);
        wait_ev(3);
        chk(waited, TICK1);
    endtask : t_rate

    task automatic t_exec;
        frame(1'b1, 8'h24, 8'h00, 8'h00, 16'h0, '0, 1'b0);
        #1;
        chk({31'h0, exec_req}, 32'h1);
        exec(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 16'h0004, 32'h3F800000);
        reply(`RSP_COMPLETION, 32'h3F800000, 16'h0004, 2'h1, 2'h1);
        frame(1'b1, 8'h30, 8'h00, 8'h00, 16'h0, '0, 1'b0);
        exec(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 16'h0004, 32'h41200000);
        reply(`RSP_PROGRESS, 32'h41200000, 16'h0004, 2'h1, 2'h1);
        exec(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 16'h0004, 32'h41200000);
        reply(`RSP_PROGRESS, 32'h0, 16'h0, 2'h1, 2'h1);
        exec(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, `NEG_LEN, 32'h0);
        reply(`RSP_NEGATIVE, `REASON_UNIMPLEMENTED, `NEG_LEN, 2'h1, 2'h1);
        for (int r = 3; r <= 13; r++) begin
            frame(1'b1, 8'h26, 8'h00, 8'h00, 16'h0, '0, 1'b0);
            exec(1'b0, 1'b1, 1'b0, 1'b0, 8'(r), `NEG_LEN, 32'h0);
            reply(`RSP_NEGATIVE, 32'(r), `NEG_LEN, 2'h1, 2'h1);
        end
    endtask : t_exec

    task automatic t_close;
        @(posedge clk);
        slow <= 1'b1;
        frame(1'b1, `CMD_CLOSE_LINK, 8'h00, 8'h00, 16'h0001, '0, 1'b0);
        reply(`RSP_NEGATIVE, `REASON_BAD_LENGTH, `NEG_LEN, 2'h1, 2'h1);
        frame(1'b1, `CMD_CLOSE_LINK, 8'h00, 8'h00, 16'h0, '0, 1'b0);
        reply(`RSP_COMPLETION, 32'h0, 16'h0, 2'h1, 2'h0);
        st({2'b00, SESS_NONE});
    endtask : t_close

    task automatic t_secret;
        wrreg(`REG_SECRET_BASE, 32'hA0A1A2A3);
        wrreg(`REG_SECRET_BASE + 8'h04, 32'hA4A5A6A7);
        wrreg(`REG_CONTROL, 32'h1);
        open(8'h00, 8'h00, 1'b1);
        reply(`RSP_COMPLETION, 32'h0, 16'h0, 2'h0, 2'h0);
        st({2'b00, SESS_RESTRICTED});
        frame(1'b1, 8'h23, 8'h00, 8'h00, 16'h0, '0, 1'b1);
        reply(`RSP_NEGATIVE, `REASON_ACCESS_DENIED, `NEG_LEN, 2'h0, 2'h0);
        open(8'h00, 8'h05, 1'b0);
        reply(`RSP_COMPLETION, 32'h0, 16'h0, 2'h0, 2'h0);
        open(8'h02, 8'h05, 1'b1);
        reply(`RSP_NEGATIVE, `REASON_ACCESS_DENIED, `NEG_LEN, 2'h0, 2'h0);
        st({2'b00, SESS_FULL});
    endtask : t_secret

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_idle;
        t_refuse;
        t_rate;
        t_exec;
        t_close;
        t_secret;
        end_of_test;
    end

    // About 6000 cycles are needed; cut a hang at 50000
    initial begin
        #1000000;
        errors++;
        end_of_test;
    end
endmodule : test_remote_session_responder
`default_nettype wire
